/* File: core/bbs_exec_core.sv */
/*
  Executor for bit, branch, system control and block move instructions,
  with its own general registers, condition byte and program counter.
  Assumes an instruction source that presents the word at pc with its
  extension, and a memory slave that answers each request with mem_ack.
*/
`include "bbs_map.svh"

// ****************************************
// bit, branch and system executor
// ****************************************
module bbs_exec_core
  import bbs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // software port
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // instruction supply
  input wire logic ins_valid,
  input wire logic [15:0] ins_word,
  input wire logic [31:0] ins_ext,
  output logic ins_ready,
  output logic [23:0] pc,
  // memory bus
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // status
  output logic sleeping
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [7:0] byte_of(input logic [31:0] r, input logic lo);
    byte_of = lo ? r[7:0] : r[15:8];
  endfunction

  function automatic logic [31:0] byte_put(input logic [31:0] r, input logic lo,
                                           input logic [7:0] b);
    byte_put = lo ? {r[31:8], b} : {r[31:16], b, r[7:0]};
  endfunction

  function automatic logic cc_true(input logic [3:0] cc, input logic [7:0] f);
    logic c;
    logic z;
    logic v;
    logic n;
    c = f[`BBS_CCR_C];
    z = f[`BBS_CCR_Z];
    v = f[`BBS_CCR_V];
    n = f[`BBS_CCR_N];
    unique case (cc)
      4'h0: cc_true = 1'b1;
      4'h1: cc_true = 1'b0;
      4'h2: cc_true = ~(c | z);
      4'h3: cc_true = c | z;
      4'h4: cc_true = ~c;
      4'h5: cc_true = c;
      4'h6: cc_true = ~z;
      4'h7: cc_true = z;
      4'h8: cc_true = ~v;
      4'h9: cc_true = v;
      4'ha: cc_true = ~n;
      4'hb: cc_true = n;
      4'hc: cc_true = ~(n ^ v);
      4'hd: cc_true = n ^ v;
      4'he: cc_true = ~(z | (n ^ v));
      4'hf: cc_true = z | (n ^ v);
    endcase
  endfunction

  function automatic logic [23:0] ins_len(input logic [3:0] op);
    if (op == `BBS_OP_BIT_AI || op == `BBS_OP_BIT_AR) begin
      ins_len = 24'h000004;
    end else if (op == `BBS_OP_JMP_ABS || op == `BBS_OP_JSR_ABS) begin
      ins_len = 24'h000006;
    end else begin
      ins_len = 24'h000002;
    end
  endfunction

  function automatic logic [15:0] cnt_of(input logic [31:0] r, input logic w);
    cnt_of = w ? r[15:0] : {8'h00, r[7:0]};
  endfunction

  // ****************************************
  // state
  // ****************************************
  bbs_state_e state;
  logic [31:0] gr [8];
  logic [7:0] condition_code_byte;
  logic run_en;
  logic ill;
  logic [15:0] iw;
  logic [2:0] bn;
  logic [15:0] hold;
  logic [23:0] tgt;

  // ****************************************
  // decode of the offered word
  // ****************************************
  wire take = ins_valid & ins_ready;
  wire [3:0] opf = ins_word[15:12];
  wire [3:0] sub = ins_word[11:8];
  wire [31:0] areg = gr[ins_word[2:0]];
  wire [7:0] dbyte = byte_of(gr[ins_word[2:0]], ins_word[3]);
  wire [7:0] nbyte = byte_of(gr[ins_word[6:4]], ins_word[7]);
  wire is_bit = (opf >= `BBS_OP_BIT_RI) && (opf <= `BBS_OP_BIT_AR);
  wire reg_form = (opf == `BBS_OP_BIT_RR) || (opf == `BBS_OP_BIT_IR)
    || (opf == `BBS_OP_BIT_AR);
  wire bit_bad = is_bit && ((sub > 4'hd) || (reg_form && sub > 4'h3));
  wire abs_op = (opf == `BBS_OP_JMP_ABS) || (opf == `BBS_OP_JSR_ABS);
  wire abs_bad = abs_op && (ins_ext[31:24] != 8'h00);
  wire [2:0] bnum_now = reg_form ? nbyte[2:0] : ins_word[6:4];
  wire [23:0] ea_bit = (opf >= `BBS_OP_BIT_AI) ?
    {`BBS_ABS8_HI, ins_ext[7:0]} : areg[23:0];
  wire [23:0] pc_seq = pc + ins_len(opf);
  wire [23:0] rel_tgt = pc_seq + {{16{ins_word[7]}}, ins_word[7:0]};
  wire [23:0] sp_dn = gr[`BBS_SP][23:0] - 24'h000004;
  wire blk_w_now = (sub == block_move_word_op);
  wire blk_w_held = (iw[11:8] == block_move_word_op);
  wire [15:0] cnt_now = cnt_of(gr[`BBS_CNT], blk_w_now);
  wire [15:0] cnt_left = cnt_of(gr[`BBS_CNT], blk_w_held) - 16'h0001;
  wire in_bit_rd = (state == st_bit_rd);

  // ****************************************
  // bit unit
  // ****************************************
  wire [7:0] alu_dout;
  wire alu_c;
  wire alu_z;
  wire alu_wr;

  bbs_bit_alu u_alu (
    .op(in_bit_rd ? iw[11:8] : sub),
    .bnum(in_bit_rd ? bn : bnum_now),
    .din(in_bit_rd ? mem_rdata[7:0] : dbyte),
    .cin(condition_code_byte[`BBS_CCR_C]),
    .zin(condition_code_byte[`BBS_CCR_Z]),
    .dout(alu_dout),
    .cout(alu_c),
    .zout(alu_z),
    .wr(alu_wr)
  );

  // ****************************************
  // software port decode
  // ****************************************
  wire gr_hit = (sw_addr[7:5] == `BBS_GR_BASE) && (sw_addr[1:0] == 2'b00);
  wire sw_gr_wr = sw_wr && gr_hit;
  wire ctrl_wr = sw_wr && (sw_addr == `BBS_CTRL_OFS);
  wire wake = ctrl_wr && sw_wdata[`BBS_CTRL_WAKE];
  wire ill_clr = sw_wr && (sw_addr == `BBS_STAT_OFS) && sw_wdata[`BBS_STAT_ILL];
  wire [31:0] rd_mux = (sw_addr == `BBS_CTRL_OFS) ? {31'h0, run_en} :
    (sw_addr == `BBS_STAT_OFS) ? {30'h0, ill, sleeping} :
    (sw_addr == `BBS_CCR_OFS) ? {24'h0, condition_code_byte} :
    (sw_addr == `BBS_PC_OFS) ? {8'h0, pc} :
    gr_hit ? gr[sw_addr[4:2]] : 32'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_rdata <= 32'h0;
      run_en <= `BBS_CTRL_RST;
    end else begin
      sw_rdata <= sw_rd ? rd_mux : 32'h0;
      if (ctrl_wr) begin
        run_en <= sw_wdata[`BBS_CTRL_RUN];
      end
    end
  end

  // ****************************************
  // memory request
  // ****************************************
  task automatic mem_go(input logic we, input logic by, input logic [23:0] a,
                        input logic [15:0] d);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_byte <= by;
    mem_addr <= by ? a : {a[23:1], 1'b0};
    mem_wdata <= d;
  endtask

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_run;
      pc <= `BBS_PC_RST;
      condition_code_byte <= `BBS_CCR_RST;
      ins_ready <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= 24'h0;
      mem_wdata <= 16'h0;
      sleeping <= 1'b0;
      ill <= 1'b0;
      iw <= 16'h0;
      bn <= 3'h0;
      hold <= 16'h0;
      tgt <= 24'h0;
      for (int i = 0; i < 8; i++) begin
        gr[i] <= 32'h0;
      end
    end else begin
      if (sw_gr_wr) begin
        gr[sw_addr[4:2]] <= sw_wdata;
      end
      if (ill_clr) begin
        ill <= 1'b0;
      end
      if (mem_ack) begin
        mem_req <= 1'b0;
      end
      unique case (state)
        st_run: begin
          ins_ready <= run_en & ~take;
          if (take) begin
            iw <= ins_word;
            bn <= bnum_now;
            pc <= pc_seq;
            if (bit_bad || abs_bad) begin
              ill <= 1'b1;
            end else begin
              unique case (opf)
                `BBS_OP_BIT_RI, `BBS_OP_BIT_RR: begin
                  if (alu_wr) begin
                    gr[ins_word[2:0]] <= byte_put(areg, ins_word[3], alu_dout);
                  end
                  condition_code_byte[`BBS_CCR_C] <= alu_c;
                  condition_code_byte[`BBS_CCR_Z] <= alu_z;
                end
                `BBS_OP_BIT_II, `BBS_OP_BIT_IR, `BBS_OP_BIT_AI, `BBS_OP_BIT_AR: begin
                  mem_go(1'b0, 1'b1, ea_bit, 16'h0);
                  state <= st_bit_rd;
                end
                `BBS_OP_BCC: begin
                  if (cc_true(sub, condition_code_byte)) begin
                    pc <= rel_tgt;
                  end
                end
                `BBS_OP_JMP_IND: pc <= {areg[23:1], 1'b0};
                `BBS_OP_JMP_ABS: pc <= {ins_ext[23:1], 1'b0};
                `BBS_OP_JSR_IND, `BBS_OP_JSR_ABS, `BBS_OP_BSR: begin
                  tgt <= (opf == `BBS_OP_BSR) ? rel_tgt :
                    (opf == `BBS_OP_JSR_ABS) ? ins_ext[23:0] : areg[23:0];
                  hold <= pc_seq[15:0];
                  gr[`BBS_SP] <= {gr[`BBS_SP][31:24], sp_dn};
                  mem_go(1'b1, 1'b0, sp_dn, {8'h00, pc_seq[23:16]});
                  state <= st_push_hi;
                end
                `BBS_OP_SYS: begin
                  unique case (bbs_sysop_e'(sub))
                    no_operation_op: ;
                    sleep_op: begin
                      sleeping <= 1'b1;
                      state <= st_sleep;
                    end
                    trap_op: begin
                      tgt <= `BBS_TRAP_BASE + {20'h0, ins_word[1:0], 2'b00};
                      hold <= pc_seq[15:0];
                      gr[`BBS_SP] <= {gr[`BBS_SP][31:24], sp_dn};
                      mem_go(1'b1, 1'b0, sp_dn, {condition_code_byte, pc_seq[23:16]});
                      condition_code_byte[`BBS_CCR_I] <= 1'b1;
                      state <= st_push_hi;
                    end
                    exception_return_op, subroutine_return_op: begin
                      mem_go(1'b0, 1'b0, gr[`BBS_SP][23:0], 16'h0);
                      state <= st_pop_hi;
                    end
                    and_condition_imm_op: condition_code_byte <= condition_code_byte & ins_word[7:0];
                    or_condition_imm_op: condition_code_byte <= condition_code_byte | ins_word[7:0];
                    xor_condition_imm_op: condition_code_byte <= condition_code_byte ^ ins_word[7:0];
                    load_condition_byte_op: condition_code_byte <= ins_word[7:0];
                    load_condition_reg_op: condition_code_byte <= dbyte;
                    store_condition_byte_op: begin
                      gr[ins_word[2:0]] <= byte_put(areg, ins_word[3], condition_code_byte);
                    end
                    load_condition_mem_op: begin
                      mem_go(1'b0, 1'b0, areg[23:0], 16'h0);
                      state <= st_ccr_rd;
                    end
                    store_condition_mem_op: begin
                      mem_go(1'b1, 1'b0, areg[23:0], {condition_code_byte, 8'h00});
                      state <= st_ccr_wr;
                    end
                    block_move_op, block_move_word_op: begin
                      if (cnt_now != 16'h0) begin
                        mem_go(1'b0, 1'b1, gr[`BBS_SRC][23:0], 16'h0);
                        state <= st_blk_rd;
                      end
                    end
                    default: ill <= 1'b1;
                  endcase
                end
                default: ill <= 1'b1;
              endcase
            end
          end
        end
        st_bit_rd: begin
          if (mem_ack) begin
            condition_code_byte[`BBS_CCR_C] <= alu_c;
            condition_code_byte[`BBS_CCR_Z] <= alu_z;
            if (alu_wr) begin
              mem_go(1'b1, 1'b1, mem_addr, {8'h00, alu_dout});
              state <= st_bit_wr;
            end else begin
              state <= st_run;
            end
          end
        end
        st_bit_wr, st_ccr_wr: begin
          if (mem_ack) begin
            state <= st_run;
          end
        end
        st_ccr_rd: begin
          if (mem_ack) begin
            condition_code_byte <= mem_rdata[15:8];
            state <= st_run;
          end
        end
        st_push_hi: begin
          if (mem_ack) begin
            mem_go(1'b1, 1'b0, mem_addr + 24'h000002, hold);
            state <= st_push_lo;
          end
        end
        st_push_lo: begin
          if (mem_ack) begin
            if (iw[15:12] == `BBS_OP_SYS) begin
              mem_go(1'b0, 1'b0, tgt, 16'h0);
              state <= st_vec_hi;
            end else begin
              pc <= {tgt[23:1], 1'b0};
              state <= st_run;
            end
          end
        end
        st_vec_hi, st_pop_hi: begin
          if (mem_ack) begin
            hold <= mem_rdata;
            mem_go(1'b0, 1'b0, mem_addr + 24'h000002, 16'h0);
            state <= (state == st_vec_hi) ? st_vec_lo : st_pop_lo;
          end
        end
        st_vec_lo: begin
          if (mem_ack) begin
            pc <= {hold[7:0], mem_rdata[15:1], 1'b0};
            state <= st_run;
          end
        end
        st_pop_lo: begin
          if (mem_ack) begin
            pc <= {hold[7:0], mem_rdata[15:1], 1'b0};
            if (iw[11:8] == exception_return_op) begin
              condition_code_byte <= hold[15:8];
            end
            gr[`BBS_SP] <= gr[`BBS_SP] + 32'h4;
            state <= st_run;
          end
        end
        st_blk_rd: begin
          if (mem_ack) begin
            mem_go(1'b1, 1'b1, gr[`BBS_DST][23:0], {8'h00, mem_rdata[7:0]});
            state <= st_blk_wr;
          end
        end
        st_blk_wr: begin
          if (mem_ack) begin
            gr[`BBS_SRC] <= gr[`BBS_SRC] + 32'h1;
            gr[`BBS_DST] <= gr[`BBS_DST] + 32'h1;
            if (blk_w_held) begin
              gr[`BBS_CNT][15:0] <= cnt_left;
            end else begin
              gr[`BBS_CNT][7:0] <= cnt_left[7:0];
            end
            if (cnt_left == 16'h0) begin
              state <= st_run;
            end else begin
              mem_go(1'b0, 1'b1, gr[`BBS_SRC][23:0] + 24'h000001, 16'h0);
              state <= st_blk_rd;
            end
          end
        end
        st_sleep: begin
          if (wake) begin
            sleeping <= 1'b0;
            state <= st_run;
          end
        end
      endcase
    end
  end

endmodule

/* File: core/bbs_map.svh */
/*
  Constants of the bit, branch and system executor: register offsets,
  field positions, reset values and instruction field codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BBS_MAP_SVH
`define BBS_MAP_SVH

// ****************************************
// software port offsets
// ****************************************
`define BBS_CTRL_OFS 8'h00
`define BBS_STAT_OFS 8'h04
`define BBS_CCR_OFS 8'h08
`define BBS_PC_OFS 8'h0c
`define BBS_GR_BASE 3'h1
`define BBS_CTRL_RUN 0
`define BBS_CTRL_WAKE 1
`define BBS_STAT_SLEEP 0
`define BBS_STAT_ILL 1
`define BBS_CTRL_RST 1'b1

// ****************************************
// condition code byte
// ****************************************
`define BBS_CCR_C 0
`define BBS_CCR_V 1
`define BBS_CCR_Z 2
`define BBS_CCR_N 3
`define BBS_CCR_I 7
`define BBS_CCR_RST 8'h80

// ****************************************
// addresses and fixed registers
// ****************************************
`define BBS_PC_RST 24'h000100
`define BBS_TRAP_BASE 24'h000020
`define BBS_ABS8_HI 16'hffff
`define BBS_SP 3'h7
`define BBS_CNT 3'h4
`define BBS_SRC 3'h5
`define BBS_DST 3'h6

// ****************************************
// operation field codes
// ****************************************
`define BBS_OP_SYS 4'h0
`define BBS_OP_BIT_RI 4'h1
`define BBS_OP_BIT_RR 4'h2
`define BBS_OP_BIT_II 4'h3
`define BBS_OP_BIT_IR 4'h4
`define BBS_OP_BIT_AI 4'h5
`define BBS_OP_BIT_AR 4'h6
`define BBS_OP_BCC 4'h7
`define BBS_OP_JMP_IND 4'h8
`define BBS_OP_JSR_IND 4'h9
`define BBS_OP_BSR 4'ha
`define BBS_OP_JMP_ABS 4'hb
`define BBS_OP_JSR_ABS 4'hc

`endif

/* File: core/bbs_pkg.sv */
/*
  Types of the bit, branch and system executor.
  Assumes nothing of its surroundings.
*/
package bbs_pkg;

  // bit operation sub-codes, in field order
  typedef enum logic [3:0] {
    bit_set_op, bit_clear_op, bit_invert_op, bit_test_op,
    carry_and_bit_op, carry_and_inv_bit_op, carry_or_bit_op,
    carry_or_inv_bit_op, carry_xor_bit_op, carry_xor_inv_bit_op,
    bit_load_carry_op, inv_bit_load_carry_op, carry_store_bit_op,
    inv_carry_store_bit_op, bit_rsv_e_op, bit_rsv_f_op
  } bbs_bitop_e;

  // system sub-codes, in field order
  typedef enum logic [3:0] {
    no_operation_op, sleep_op, trap_op, exception_return_op,
    subroutine_return_op, and_condition_imm_op, or_condition_imm_op,
    xor_condition_imm_op, load_condition_byte_op, load_condition_reg_op,
    store_condition_byte_op, load_condition_mem_op,
    store_condition_mem_op, block_move_op, block_move_word_op, sys_rsv_op
  } bbs_sysop_e;

  typedef enum logic [3:0] {
    st_run, st_bit_rd, st_bit_wr, st_ccr_rd, st_ccr_wr, st_push_hi,
    st_push_lo, st_vec_hi, st_vec_lo, st_pop_hi, st_pop_lo, st_blk_rd,
    st_blk_wr, st_sleep
  } bbs_state_e;

endpackage

/* File: core/bbs_bit_alu.sv */
/*
  Single-bit operation unit: byte result, carry and zero.
  Assumes the caller supplies the operand byte and flags.
*/
module bbs_bit_alu
  import bbs_pkg::*;
(
  // operation
  input wire logic [3:0] op,
  input wire logic [2:0] bnum,
  // operand and flags in
  input wire logic [7:0] din,
  input wire logic cin,
  input wire logic zin,
  // results
  output logic [7:0] dout,
  output logic cout,
  output logic zout,
  output logic wr
);

  // ****************************************
  // bit select
  // ****************************************
  wire [7:0] mask = 8'h01 << bnum;
  wire sel = din[bnum];
  wire inv = (op == carry_and_inv_bit_op) || (op == carry_or_inv_bit_op)
    || (op == carry_xor_inv_bit_op) || (op == inv_bit_load_carry_op);
  wire src = inv ? ~sel : sel;

  // ****************************************
  // results
  // ****************************************
  assign dout = (op == bit_set_op) ? (din | mask) :
    (op == bit_clear_op) ? (din & ~mask) :
    (op == bit_invert_op) ? (din ^ mask) :
    (op == carry_store_bit_op) ? (cin ? din | mask : din & ~mask) :
    (op == inv_carry_store_bit_op) ? (cin ? din & ~mask : din | mask) :
    din;
  assign wr = (op == bit_set_op) || (op == bit_clear_op)
    || (op == bit_invert_op) || (op == carry_store_bit_op)
    || (op == inv_carry_store_bit_op);
  assign cout = (op == carry_and_bit_op || op == carry_and_inv_bit_op) ?
    (cin & src) :
    (op == carry_or_bit_op || op == carry_or_inv_bit_op) ? (cin | src) :
    (op == carry_xor_bit_op || op == carry_xor_inv_bit_op) ? (cin ^ src) :
    (op == bit_load_carry_op || op == inv_bit_load_carry_op) ? src :
    cin;
  assign zout = (op == bit_test_op) ? ~sel : zin;

endmodule

/* File: dv/bbs_exec_monitor.sv */
/* port checker of the bit, branch and system executor
   assumes binding to bbs_exec_core, one clock and its reset */
module bbs_exec_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic ins_valid,
  input wire logic [15:0] ins_word,
  input wire logic ins_ready,
  input wire logic [23:0] pc,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [23:0] mem_addr,
  input wire logic mem_ack,
  input wire logic sleeping
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [23:0] pc_nxt;
  logic [23:0] pc_bra;
  wire take = ins_valid && ins_ready;
  // pc expected after a taken word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_nxt <= 24'h0;
      pc_bra <= 24'h0;
    end else if (take) begin
      pc_nxt <= pc + 24'h2;
      pc_bra <= pc + 24'h2 + {{16{ins_word[7]}}, ins_word[7:0]};
    end
  end
  a_take_ready: assert property (take |=> !ins_ready)
    else $error("ready held after take");
  a_nop_pc: assert property (take && ins_word == 16'h0000 |=> pc == pc_nxt)
    else $error("nop pc wrong");
  a_bra_taken: assert property (take && ins_word[15:8] == 8'h70 |=> pc == pc_bra)
    else $error("always branch wrong");
  a_brn_skip: assert property (take && ins_word[15:8] == 8'h71 |=> pc == pc_nxt)
    else $error("never branch wrong");
  a_req_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request moved");
  a_word_even: assert property (mem_req && !mem_byte |-> !mem_addr[0])
    else $error("odd word address");
  a_mem_busy: assert property (mem_req |-> !ins_ready)
    else $error("ready during memory");
  a_sleep_enter: assert property (take && ins_word == 16'h0100 |-> ##[1:3] sleeping)
    else $error("sleep not entered");
  a_sleep_block: assert property (sleeping |-> !ins_ready)
    else $error("ready while asleep");
  a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
    else $error("read data outside slot");
endmodule

bind bbs_exec_core bbs_exec_monitor u_mon (.ref_clk, .rst_n, .sw_rd, .sw_rdata, .ins_valid,
  .ins_word, .ins_ready, .pc, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_ack, .sleeping);

/* File: dv/bbs_mem_model.sv */
/* byte memory on the executor's memory bus
   assumes requests held until acknowledged */
module bbs_mem_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // answer speed
  input wire logic slow,
  // memory bus
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] wait_cnt;
  wire [7:0] a = mem_addr[7:0];
  wire [7:0] a1 = a + 8'h1;
  // data lines toggle outside read answers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
      wait_cnt <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt >= {slow, 1'b0}) begin
          mem_ack <= 1'b1;
          wait_cnt <= 2'h0;
          if (!mem_we)
            mem_rdata <= mem_byte ? {~mem[a], mem[a]} : {mem[a], mem[a1]};
          else if (mem_byte)
            mem[a] <= mem_wdata[7:0];
          else begin
            mem[a] <= mem_wdata[15:8];
            mem[a1] <= mem_wdata[7:0];
          end
        end
      end
    end
  end
endmodule

/* File: dv/tb_top.sv */
/* self-checking bench of the executor
   assumes the memory model on its bus and the bound checker */
`include "bbs_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sw_addr = 8'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic ins_valid = 1'b0;
  logic [15:0] ins_word = 16'h0;
  logic [31:0] ins_ext = 32'h0;
  logic slow = 1'b0;
  logic [31:0] sw_rdata;
  logic ins_ready, mem_req, mem_we, mem_byte, mem_ack, sleeping;
  logic [23:0] pc, mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  int n_fail = 0;
  int check_count = 0;
  always #10 ref_clk = ~ref_clk;
  bbs_exec_core dut (.ref_clk, .rst_n, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
    .ins_valid, .ins_word, .ins_ext, .ins_ready, .pc, .mem_req, .mem_we, .mem_byte,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .sleeping);
  bbs_mem_model u_mem (.ref_clk, .rst_n, .slow, .mem_req, .mem_we, .mem_byte, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic sw_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 chk(nm, e, sw_rdata);
  endtask
  task automatic ex(input logic [15:0] w, input logic [31:0] e = 32'h0, input bit back = 1'b1);
    int n = 0;
    @(posedge ref_clk);
    ins_valid <= 1'b1;
    ins_word <= w;
    ins_ext <= e;
    do @(posedge ref_clk); while (ins_ready !== 1'b1 && n++ < 300);
    ins_valid <= 1'b0;
    if (back) do @(posedge ref_clk); while (ins_ready !== 1'b1 && n++ < 300);
    chk("ready", 32'h1, {31'h0, n <= 300});
  endtask
  function automatic logic fc(int s, logic c);
    case (s)
      4, 10: return 1'b0;
      5, 6, 8: return c;
      7, 11: return 1'b1;
      default: return ~c;
    endcase
  endfunction
  function automatic logic cond(int c, logic [3:0] f);
    logic t;
    case (c >> 1)
      0: t = 1'b0;
      1: t = f[0] | f[2];
      2: t = f[0];
      3: t = f[2];
      4: t = f[1];
      5: t = f[3];
      6: t = f[3] ^ f[1];
      default: t = f[2] | (f[3] ^ f[1]);
    endcase
    return c[0] ? t : ~t;
  endfunction
  task automatic t_bits;
    logic [7:0] v = 8'h35;
    logic [7:0] m;
    sw_w(8'h20, 32'h35);
    for (int i = 0; i < 3; i++) begin
      ex(16'h1008 | 16'(i) << 8 | 16'(i * 3 + 1) << 4);
      m = 8'h1 << (i * 3 + 1);
      v = i == 0 ? v | m : i == 1 ? v & ~m : v ^ m;
      rd_chk("bit reg", 8'h20, {24'h0, v});
    end
    sw_w(8'h24, 32'h6);
    ex(16'h2098);
    rd_chk("reg bitnum", 8'h20, {24'h0, v | 8'h40});
  endtask
  task automatic t_carry;
    logic c;
    for (int k = 0; k < 2; k++)
      for (int s = 3; s < 14; s++) begin
        sw_w(8'h20, 32'h5a);
        ex(16'h1a08 | 16'(k) << 4);
        ex(16'h1028 | 16'(s) << 8);
        c = 1'(k);
        if (s == 3) rd_chk("zero", 8'h08, 32'h84 | 32'(k));
        else if (s < 12) rd_chk("carry", 8'h08, {31'h42, fc(s, c)});
        else rd_chk("store", 8'h20, 32'h5a | 32'(c ^ (s == 13)) << 2);
      end
  endtask
  task automatic t_mem;
    @(posedge ref_clk);
    slow <= 1'b1;
    sw_w(8'h24, 32'h40);
    u_mem.mem[8'h40] = 8'h81;
    u_mem.mem[8'h41] = 8'hff;
    ex(16'h3031);
    chk("rmw", 32'h89, {24'h0, u_mem.mem[8'h40]});
    ex(16'h5100, 32'h41);
    chk("abs8", 32'hfe, {24'h0, u_mem.mem[8'h41]});
  endtask
  task automatic t_branch;
    logic [23:0] p;
    logic [7:0] fl [4] = '{8'h00, 8'h05, 8'h0a, 8'h09};
    for (int j = 0; j < 4; j++) begin
      ex(16'h0800 | 16'(fl[j]));
      for (int c = 0; c < 16; c++) begin
        p = pc;
        ex(16'h7000 | 16'(c) << 8 | (c[0] ? 16'hf0 : 16'h10));
        chk("branch", {8'h0, p + 24'h2 + (cond(c, fl[j][3:0]) ?
          (c[0] ? 24'hfffff0 : 24'h10) : 24'h0)}, {8'h0, pc});
      end
    end
  endtask
  task automatic t_ccr;
    ex(16'h085a);
    ex(16'h050f);
    rd_chk("and_condition_imm_op", 8'h08, 32'h0a);
    ex(16'h0681);
    rd_chk("orc", 8'h08, 32'h8b);
    ex(16'h07ff);
    rd_chk("xor_condition_imm_op", 8'h08, 32'h74);
    ex(16'h0000);
    rd_chk("nop", 8'h08, 32'h74);
    sw_w(8'h24, 32'h51);
    ex(16'h0c01);
    chk("stc", 32'h74, {24'h0, u_mem.mem[8'h50]});
    u_mem.mem[8'h52] = 8'h03;
    sw_w(8'h24, 32'h52);
    ex(16'h0b01);
    rd_chk("ldc", 8'h08, 32'h03);
  endtask
  task automatic t_block;
    for (int i = 0; i < 3; i++) u_mem.mem[8'h60 + i] = 8'(i + 1);
    u_mem.mem[8'h73] = 8'hee;
    sw_w(8'h30, 32'h3);
    sw_w(8'h34, 32'h60);
    sw_w(8'h38, 32'h70);
    ex(16'h0d00);
    for (int i = 0; i < 3; i++) chk("copy", i + 1, {24'h0, u_mem.mem[8'h70 + i]});
    chk("stop", 32'hee, {24'h0, u_mem.mem[8'h73]});
    rd_chk("count", 8'h30, 32'h0);
    rd_chk("source", 8'h34, 32'h63);
  endtask
  task automatic t_sys;
    ex(16'hb000, 32'h00001234);
    chk("jump", 32'h1234, {8'h0, pc});
    ex(16'hb000, 32'h01002000);
    rd_chk("illegal", 8'h04, 32'h2);
    sw_w(8'h3c, 32'h80);
    {u_mem.mem[8'h25], u_mem.mem[8'h26], u_mem.mem[8'h27]} = 24'h000200;
    ex(16'ha010);
    chk("call", 32'h124c, {8'h0, pc});
    ex(16'h0400);
    chk("return", 32'h123c, {8'h0, pc});
    ex(16'h0201);
    chk("trap", 32'h200, {8'h0, pc});
    ex(16'h0300);
    chk("rte", 32'h123e, {8'h0, pc});
    rd_chk("rte ccr", 8'h08, 32'h03);
    ex(16'h0100, 32'h0, 1'b0);
    rd_chk("asleep", 8'h04, 32'h3);
    sw_w(8'h00, 32'h3);
    repeat (2) @(posedge ref_clk);
    #1 chk("wake", 32'h0, {31'h0, sleeping});
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk("pc", {8'h0, `BBS_PC_RST}, {8'h0, pc});
    rd_chk("ccr", 8'h08, {24'h0, `BBS_CCR_RST});
    rd_chk("unmapped", 8'h80, 32'h0);
    t_bits;
    t_carry;
    t_branch;
    t_mem;
    t_ccr;
    t_block;
    t_sys;
    test_done;
  end
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
endmodule
